// >>> bench/memory_map_ber_counter_tb.sv
// Bench joining controller and switch end over the host port
`timescale 1ns/1ps
`default_nettype none
module memory_map_ber_counter_tb;
	logic        pclk         = 1'b0;
	logic        presetn      = 1'b0;
	logic [7:0]  paddr        = 8'h00;
	logic        psel         = 1'b0;
	logic        penable      = 1'b0;
	logic        pwrite       = 1'b0;
	logic [31:0] pwdata       = 32'h0000_0000;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        irq;
	logic [63:0] stream_rate  = {32{mmb_pkg::RATE_16M}};
	logic [31:0] test_active  = 32'h0000_0000;
	logic [31:0] bit_valid    = 32'h0000_0000;
	logic [31:0] bit_mismatch = 32'h0000_0000;
	logic [12:0] cm_raddr     = 13'h0000;
	logic        dm_we        = 1'b0;
	logic [12:0] dm_addr      = 13'h0000;
	logic [15:0] dm_wdata     = 16'h0000;
	logic [15:0] cm_low_q;
	logic [15:0] cm_high_q;
	logic [15:0] control_q;
	logic        perr;
	logic        last_irq;
	logic [15:0] q;
	logic [1:0]  s;
	logic [31:0] r;
	int          bad_count    = 0;
	int          checks_done  = 0;
	int          cyc          = 0;

	mmb_if bus_if ();

	always #2.5 pclk = ~pclk;

	mmb_dev i_mmb_dev (.pclk(pclk), .presetn(presetn), .bus(bus_if.dev),
		.stream_rate(stream_rate), .test_active(test_active),
		.bit_valid(bit_valid), .bit_mismatch(bit_mismatch),
		.dm_we(dm_we), .dm_addr(dm_addr), .dm_wdata(dm_wdata),
		.cm_raddr(cm_raddr), .cm_low_q(cm_low_q), .cm_high_q(cm_high_q),
		.control_q(control_q));
	mmb_host i_mmb_host (.pclk(pclk), .presetn(presetn), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
		.bus(bus_if.host));
	mmb_monitor i_mmb_monitor (.pclk(pclk), .presetn(presetn),
		.req(bus_if.req), .we(bus_if.we), .addr(bus_if.addr),
		.wdata(bus_if.wdata), .rdata(bus_if.rdata), .ack(bus_if.ack));

	////////////////////////////////////////////////////////////////////////
	task summarize();
		$display("Checks: %0d, mismatches: %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : summarize

	task chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH %0t got %h expected %h", $time, g, e);
		end
	endtask : chk

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rv);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rv = prdata;
		perr = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Command: address, data, command word, then poll busy
	task xfer(input logic [12:0] a, input logic [15:0] d,
		input logic [4:0] c, output logic [15:0] qv, output logic [1:0] sv);
		logic [31:0] v;
		int          n;
		apb(1'b1, mmb_pkg::REG_ADDR, {19'h0_0000, a}, v);
		apb(1'b1, mmb_pkg::REG_WDATA, {16'h0000, d}, v);
		apb(1'b1, mmb_pkg::REG_CMD, {27'h000_0000, c}, v);
		n = 0;
		do begin
			apb(1'b0, mmb_pkg::REG_STAT, 32'h0000_0000, v);
			n++;
		end while (v[0] !== 1'b0 && n < 40);
		if (v[0] !== 1'b0) begin
			bad_count++;
			$display("MISMATCH %0t busy did not clear", $time);
		end
		apb(1'b0, mmb_pkg::REG_RDATA, 32'h0000_0000, v);
		qv = v[15:0];
		apb(1'b0, mmb_pkg::REG_INT_STAT, 32'h0000_0000, v);
		sv = v[1:0];
		last_irq = irq;
		apb(1'b1, mmb_pkg::REG_INT_CLR, 32'h0000_0003, v);
	endtask : xfer

	task rd(input logic [12:0] a, input logic [4:0] c, input logic [15:0] e);
		xfer(a, 16'h0000, c, q, s);
		chk(q, e);
	endtask : rd

	////////////////////////////////////////////////////////////////////////
	task t_unmapped();
		apb(1'b0, 8'h20, 32'h0000_0000, r);
		chk(perr, 1'b1);
		apb(1'b0, mmb_pkg::REG_STAT, 32'h0000_0000, r);
		chk(perr, 1'b0);
	endtask : t_unmapped

	task t_mem();
		xfer(13'h0000, 16'h0001, 5'b00011, q, s);
		chk(control_q, 16'h0001);
		xfer(13'h0205, 16'hA5A5, 5'b11111, q, s);
		xfer(13'h0000, 16'h0002, 5'b00011, q, s);
		xfer(13'h0205, 16'h5A5A, 5'b11111, q, s);
		rd(13'h0205, 5'b11101, 16'h5A5A);
		rd(13'h0000, 5'b00001, 16'h0002);
		xfer(13'h0000, 16'h0001, 5'b00011, q, s);
		rd(13'h0205, 5'b11101, 16'hA5A5);
		cm_raddr <= 13'h0205;
		repeat (2) @(posedge pclk);
		chk(cm_low_q, 16'hA5A5);
		chk(cm_high_q, 16'h5A5A);
	endtask : t_mem

	task t_rate();
		logic [7:0] ch;
		for (int k = 0; k < 4; k++) begin
			ch = 8'((32 << k) - 1);
			stream_rate[15:14] <= 2'(k);
			xfer({5'd7, ch}, 16'h1000 + 16'(k), {2'(k), 3'b111}, q, s);
			rd({5'd7, ch}, {2'(k), 3'b101}, 16'h1000 + 16'(k));
			if (k < 3) begin
				xfer({5'd7, ch + 8'h01}, 16'h0BAD, {2'(k), 3'b111}, q, s);
				chk(s[1], 1'b1);
				// Controller lets it pass, switch end must refuse it
				xfer({5'd7, ch + 8'h01}, 16'h0BAD, 5'b11111, q, s);
				rd({5'd7, ch + 8'h01}, 5'b11101, 16'h0000);
			end
		end
	endtask : t_rate

	task t_irq();
		apb(1'b1, mmb_pkg::REG_INT_EN, 32'h0000_0001, r);
		rd(13'h0000, 5'b00001, 16'h0001);
		chk(last_irq, 1'b1);
		@(posedge pclk);
		chk(irq, 1'b0);
		apb(1'b1, mmb_pkg::REG_INT_EN, 32'h0000_0000, r);
		rd(13'h0000, 5'b00001, 16'h0001);
		chk(last_irq, 1'b0);
	endtask : t_irq

	// Data memory: fill from switch side, host read only; select 3 empty
	task t_dm();
		dm_addr  <= 13'h1F40;
		dm_wdata <= 16'hC3C3;
		dm_we    <= 1'b1;
		@(posedge pclk);
		dm_we    <= 1'b0;
		xfer(13'h0000, 16'h0000, 5'b00011, q, s);
		chk(control_q, 16'h0000);
		xfer(13'h1F40, 16'h1111, 5'b11111, q, s);
		rd(13'h1F40, 5'b11101, 16'hC3C3);
		xfer(13'h0000, 16'h0003, 5'b00011, q, s);
		rd(13'h0205, 5'b11101, 16'h0000);
		xfer(13'h0000, 16'h0001, 5'b00011, q, s);
	endtask : t_dm

	task t_count();
		test_active <= 32'h8000_0019;
		@(posedge pclk);
		bit_valid    <= 32'h8000_0019;
		bit_mismatch <= 32'h8000_0009;
		repeat (5) @(posedge pclk);
		bit_mismatch <= 32'h0000_0001;
		repeat (65540) @(posedge pclk);
		bit_mismatch <= 32'h0000_0000;
		rd(13'h0360, 5'b00001, 16'hFFFF);
		rd(13'h0363, 5'b00001, 16'h0005);
		rd(13'h037F, 5'b00001, 16'h0005);
		rd(13'h0364, 5'b00001, 16'h0000);
		xfer(13'h0363, 16'h1234, 5'b00011, q, s);
		rd(13'h0363, 5'b00001, 16'h0005);
	endtask : t_count

	////////////////////////////////////////////////////////////////////////
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 85000) begin
			bad_count++;
			summarize();
		end
	end

	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		t_unmapped();
		t_mem();
		t_rate();
		t_irq();
		t_dm();
		t_count();
		summarize();
	end
endmodule : memory_map_ber_counter_tb
`default_nettype wire

// >>> bench/mmb_monitor.sv
// Handshake checker for the parallel host port
`timescale 1ns/1ps
`default_nettype none
module mmb_monitor (
	// Clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// Host port
	input wire logic        req,
	input wire logic        we,
	input wire logic [13:0] addr,
	input wire logic [15:0] wdata,
	input wire logic [15:0] rdata,
	input wire logic        ack
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	////////////////////////////////////////////////////////////////////////
	a_ack_latency: assert property ($rose(req) |-> ##[2:3] ack)
		else $error("ack not within three cycles of request");
	a_ack_pulse: assert property (ack |=> !ack [*2])
		else $error("ack longer than one cycle");
	a_ack_needs_req: assert property (ack |-> req)
		else $error("ack without request");
	a_req_release: assert property (ack |=> !req)
		else $error("request kept after ack");
	a_req_hold: assert property (req && !ack |=> req)
		else $error("request dropped before ack");
	a_addr_hold: assert property (req && !ack |=>
		$stable(addr) && $stable(we) && $stable(wdata))
		else $error("address or data moved during request");
	a_rdata_hold: assert property (!req && !ack |-> $stable(rdata))
		else $error("read data changed while idle");
	a_gap_quiet: assert property ($fell(req) |-> !ack)
		else $error("ack after request release");

	cover property (ack && !we && !addr[13]);
	cover property (ack && we && addr[13]);
	cover property (ack && !we && addr[13]);
endmodule : mmb_monitor
`default_nettype wire

// >>> rtl/mmb_dev.sv
// Switch end: host port decode, memories and error counters
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module mmb_dev (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// Host port
	mmb_if.dev               bus,
	// Per-stream rate, two bits per stream
	input  wire logic [63:0] stream_rate,
	// Bit error test receivers
	input  wire logic [31:0] test_active,
	input  wire logic [31:0] bit_valid,
	input  wire logic [31:0] bit_mismatch,
	// Data memory fill from switching path
	input  wire logic        dm_we,
	input  wire logic [12:0] dm_addr,
	input  wire logic [15:0] dm_wdata,
	// Connection memory read by switching path
	input  wire logic [12:0] cm_raddr,
	output logic      [15:0] cm_low_q,
	output logic      [15:0] cm_high_q,
	// Control register contents
	output logic      [15:0] control_q
);

	////////////////////////////////////////////////////////////////////////
	// Decode

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_LOOK,
		ST_ACK,
		ST_DONE
	} mmb_dev_state_t;

	mmb_dev_state_t state_reg;
	mmb_dev_state_t state_next;
	logic [15:0]    rdata_reg;
	logic [15:0]    rdata_next;
	logic [15:0]    ctrl_reg;
	logic [15:0]    ctrl_next;
	logic [12:0]    loc;
	logic [4:0]     stream;
	logic [7:0]     chan;
	logic [1:0]     rate;
	logic           in_frame;
	logic           is_mem;
	logic           is_ber;
	logic           cml_we;
	logic           cmh_we;

	assign loc    = bus.addr[12:0];
	assign is_mem = bus.addr[mmb_pkg::MEM_BIT];
	assign stream = bus.addr[12:8];
	assign chan   = bus.addr[7:0];
	assign rate   = stream_rate[{stream, 1'b0} +: 2];
	assign in_frame = mmb_pkg::chan_ok(rate, chan);
	assign is_ber = (loc >= mmb_pkg::BER_BASE) && (loc <= mmb_pkg::BER_LAST);

	////////////////////////////////////////////////////////////////////////
	// Error counters

	logic [31:0] active_reg;
	logic [31:0] cnt_clear;
	logic [31:0] cnt_inc;
	logic [15:0] cnt [0:31];

	// A fresh test run starts from zero
	assign cnt_clear = test_active & ~active_reg;
	assign cnt_inc   = test_active & bit_valid & bit_mismatch;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			active_reg <= 32'h0000_0000;
		else
			active_reg <= test_active;
	end

	genvar gi;
	generate
		for (gi = 0; gi < mmb_pkg::STREAMS; gi++) begin : g_cnt
			mmb_sat_cnt u_cnt (
				.pclk    (pclk),
				.presetn (presetn),
				.clear   (cnt_clear[gi]),
				.inc     (cnt_inc[gi]),
				.count_q (cnt[gi])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Memories

	logic [15:0] dm  [0:mmb_pkg::MEM_DEPTH-1];
	logic [15:0] cml [0:mmb_pkg::MEM_DEPTH-1];
	logic [15:0] cmh [0:mmb_pkg::MEM_DEPTH-1];
	logic [15:0] dm_rd;
	logic [15:0] cml_rd;
	logic [15:0] cmh_rd;

	// Reads follow the held address, so they are ready in ST_LOOK
	always_ff @(posedge pclk) begin
		if (dm_we)
			dm[dm_addr] <= dm_wdata;
		if (cml_we)
			cml[loc] <= bus.wdata;
		if (cmh_we)
			cmh[loc] <= bus.wdata;
		dm_rd     <= dm[loc];
		cml_rd    <= cml[loc];
		cmh_rd    <= cmh[loc];
		cm_low_q  <= cml[cm_raddr];
		cm_high_q <= cmh[cm_raddr];
	end

	////////////////////////////////////////////////////////////////////////
	// Access sequencer

	always_comb begin
		state_next = state_reg;
		rdata_next = rdata_reg;
		ctrl_next  = ctrl_reg;
		cml_we     = 1'b0;
		cmh_we     = 1'b0;
		unique case (state_reg)
			ST_IDLE: begin
				if (bus.req)
					state_next = ST_LOOK;
			end
			ST_LOOK: begin
				state_next = ST_ACK;
				rdata_next = 16'h0000;
				if (is_mem) begin
					if (in_frame) begin
						case (ctrl_reg[1:0])
							mmb_pkg::SEL_DM: rdata_next = dm_rd;
							mmb_pkg::SEL_CML: begin
								rdata_next = cml_rd;
								cml_we     = bus.we;
							end
							mmb_pkg::SEL_CMH: begin
								rdata_next = cmh_rd;
								cmh_we     = bus.we;
							end
							default: rdata_next = 16'h0000;
						endcase
					end
				end else if (loc == mmb_pkg::CTRL_OFF) begin
					rdata_next = ctrl_reg;
					if (bus.we)
						ctrl_next = bus.wdata;
				end else if (is_ber) begin
					// Writes here are dropped
					rdata_next = cnt[loc[4:0]];
				end
			end
			ST_ACK: begin
				state_next = bus.req ? ST_DONE : ST_IDLE;
			end
			ST_DONE: begin
				if (!bus.req)
					state_next = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= ST_IDLE;
			rdata_reg <= 16'h0000;
			ctrl_reg  <= mmb_pkg::CTRL_RESET;
		end else begin
			state_reg <= state_next;
			rdata_reg <= rdata_next;
			ctrl_reg  <= ctrl_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs

	assign bus.ack   = (state_reg == ST_ACK);
	assign bus.rdata = rdata_reg;
	assign control_q = ctrl_reg;

endmodule : mmb_dev
`default_nettype wire

// >>> rtl/mmb_host.sv
// Controller end: APB command registers driving the host port
`timescale 1ns/1ps
`default_nettype none
module mmb_host (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Interrupt
	output logic             irq,
	// Host port
	mmb_if.host              bus
);

	typedef enum logic {
		H_IDLE,
		H_WAIT
	} mmb_host_state_t;

	mmb_host_state_t state_reg;
	mmb_host_state_t state_next;
	logic [12:0] loc_reg;
	logic [12:0] loc_next;
	logic [15:0] wdata_reg;
	logic [15:0] wdata_next;
	logic [15:0] rdata_reg;
	logic [15:0] rdata_next;
	logic        req_reg;
	logic        req_next;
	logic        we_reg;
	logic        we_next;
	logic        mem_reg;
	logic        mem_next;
	logic [1:0]  ist_reg;
	logic [1:0]  ist_next;
	logic [1:0]  ien_reg;
	logic [1:0]  ien_next;
	logic [31:0] prdata_reg;
	logic [31:0] prdata_next;
	logic [1:0]  ev;
	logic [1:0]  clr;
	logic        wr_en;
	logic        mapped;
	logic        go_cmd;

	////////////////////////////////////////////////////////////////////////
	// Register access and command sequencer

	assign wr_en  = psel && penable && pwrite;
	assign mapped = (paddr <= mmb_pkg::REG_INT_EN) && (paddr[1:0] == 2'h0);
	assign go_cmd = wr_en && (paddr == mmb_pkg::REG_CMD) &&
		pwdata[mmb_pkg::CMD_GO];

	always_comb begin
		state_next  = state_reg;
		loc_next    = loc_reg;
		wdata_next  = wdata_reg;
		rdata_next  = rdata_reg;
		req_next    = req_reg;
		we_next     = we_reg;
		mem_next    = mem_reg;
		ien_next    = ien_reg;
		prdata_next = prdata_reg;
		ev          = 2'h0;
		clr         = 2'h0;
		if (wr_en) begin
			case (paddr)
				mmb_pkg::REG_ADDR:    loc_next = pwdata[12:0];
				mmb_pkg::REG_WDATA:   wdata_next = pwdata[15:0];
				mmb_pkg::REG_INT_CLR: clr = pwdata[1:0];
				mmb_pkg::REG_INT_EN:  ien_next = pwdata[1:0];
				default: ;
			endcase
		end
		unique case (state_reg)
			H_IDLE: begin
				if (go_cmd) begin
					if (pwdata[mmb_pkg::CMD_MEM] && !mmb_pkg::chan_ok(
						pwdata[mmb_pkg::CMD_RATE +: 2], loc_reg[7:0]))
						ev[mmb_pkg::INT_RANGE] = 1'b1;
					else begin
						req_next   = 1'b1;
						we_next    = pwdata[mmb_pkg::CMD_WRITE];
						mem_next   = pwdata[mmb_pkg::CMD_MEM];
						state_next = H_WAIT;
					end
				end
			end
			H_WAIT: begin
				if (bus.ack) begin
					req_next   = 1'b0;
					rdata_next = bus.rdata;
					ev[mmb_pkg::INT_DONE] = 1'b1;
					state_next = H_IDLE;
				end
			end
		endcase
		// Set wins over clear
		ist_next = (ist_reg & ~clr) | ev;
		if (psel && !penable && !pwrite) begin
			prdata_next = 32'h0000_0000;
			case (paddr)
				mmb_pkg::REG_ADDR:     prdata_next[12:0] = loc_reg;
				mmb_pkg::REG_WDATA:    prdata_next[15:0] = wdata_reg;
				mmb_pkg::REG_STAT:     prdata_next[0] = (state_reg == H_WAIT);
				mmb_pkg::REG_RDATA:    prdata_next[15:0] = rdata_reg;
				mmb_pkg::REG_INT_STAT: prdata_next[1:0] = ist_reg;
				mmb_pkg::REG_INT_EN:   prdata_next[1:0] = ien_reg;
				default: ;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg  <= H_IDLE;
			loc_reg    <= 13'h0000;
			wdata_reg  <= 16'h0000;
			rdata_reg  <= 16'h0000;
			req_reg    <= 1'b0;
			we_reg     <= 1'b0;
			mem_reg    <= 1'b0;
			ist_reg    <= 2'h0;
			ien_reg    <= 2'h0;
			prdata_reg <= 32'h0000_0000;
		end else begin
			state_reg  <= state_next;
			loc_reg    <= loc_next;
			wdata_reg  <= wdata_next;
			rdata_reg  <= rdata_next;
			req_reg    <= req_next;
			we_reg     <= we_next;
			mem_reg    <= mem_next;
			ist_reg    <= ist_next;
			ien_reg    <= ien_next;
			prdata_reg <= prdata_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs

	assign bus.req   = req_reg;
	assign bus.we    = we_reg;
	assign bus.addr  = {mem_reg, loc_reg};
	assign bus.wdata = wdata_reg;
	assign prdata    = prdata_reg;
	assign pready    = 1'b1;
	assign pslverr   = psel && penable && !mapped;
	assign irq       = |(ist_reg & ien_reg);

endmodule : mmb_host
`default_nettype wire

// >>> rtl/mmb_if.sv
// Parallel host port between controller and switch
`timescale 1ns/1ps
`default_nettype none
interface mmb_if ();
	logic        req;
	logic        we;
	logic [13:0] addr;
	logic [15:0] wdata;
	logic [15:0] rdata;
	logic        ack;

	modport dev (input req, we, addr, wdata, output rdata, ack);
	modport host (output req, we, addr, wdata, input rdata, ack);
endinterface : mmb_if
`default_nettype wire

// >>> rtl/mmb_pkg.sv
// Shared constants for the switch host port and its controller
package mmb_pkg;

	////////////////////////////////////////////////////////////////////////
	// Host port geometry
	localparam int ADDR_W    = 14;
	localparam int DATA_W    = 16;
	localparam int LOC_W     = 13;
	localparam int CHAN_W    = 8;
	localparam int STREAM_W  = 5;
	localparam int STREAMS   = 32;
	localparam int MEM_DEPTH = 8192;
	localparam int MEM_BIT   = 13;

	////////////////////////////////////////////////////////////////////////
	// Register space, A13 low
	localparam logic [12:0] CTRL_OFF   = 13'h0000;
	localparam logic [12:0] BER_BASE   = 13'h0360;
	localparam logic [12:0] BER_LAST   = 13'h037F;
	localparam logic [15:0] CTRL_RESET = 16'h0000;
	localparam logic [15:0] CNT_MAX    = 16'hFFFF;
	localparam logic [15:0] CNT_ZERO   = 16'h0000;

	// Memory select, control bits 1..0
	localparam logic [1:0] SEL_DM  = 2'h0;
	localparam logic [1:0] SEL_CML = 2'h1;
	localparam logic [1:0] SEL_CMH = 2'h2;

	// Stream rates
	localparam logic [1:0] RATE_2M  = 2'h0;
	localparam logic [1:0] RATE_4M  = 2'h1;
	localparam logic [1:0] RATE_8M  = 2'h2;
	localparam logic [1:0] RATE_16M = 2'h3;

	////////////////////////////////////////////////////////////////////////
	// Controller APB map
	localparam logic [7:0] REG_ADDR     = 8'h00;
	localparam logic [7:0] REG_WDATA    = 8'h04;
	localparam logic [7:0] REG_CMD      = 8'h08;
	localparam logic [7:0] REG_STAT     = 8'h0C;
	localparam logic [7:0] REG_RDATA    = 8'h10;
	localparam logic [7:0] REG_INT_STAT = 8'h14;
	localparam logic [7:0] REG_INT_CLR  = 8'h18;
	localparam logic [7:0] REG_INT_EN   = 8'h1C;
	localparam int CMD_GO    = 0;
	localparam int CMD_WRITE = 1;
	localparam int CMD_MEM   = 2;
	localparam int CMD_RATE  = 3;
	localparam int INT_DONE  = 0;
	localparam int INT_RANGE = 1;

	// Channel lies inside the stream's frame at this rate
	function automatic logic chan_ok(input logic [1:0] rate,
		input logic [7:0] ch);
		logic ok;
		ok = 1'b1;
		unique case (rate)
			RATE_2M:  ok = (ch[7:5] == 3'h0);
			RATE_4M:  ok = (ch[7:6] == 2'h0);
			RATE_8M:  ok = (ch[7] == 1'b0);
			RATE_16M: ok = 1'b1;
		endcase
		return ok;
	endfunction : chan_ok

endpackage : mmb_pkg

// >>> rtl/mmb_sat_cnt.sv
// Saturating 16-bit error counter
`timescale 1ns/1ps
`default_nettype none
module mmb_sat_cnt (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// Control
	input  wire logic        clear,
	input  wire logic        inc,
	// Count
	output logic      [15:0] count_q
);
	logic [15:0] count_reg;
	logic [15:0] count_next;

	always_comb begin
		count_next = count_reg;
		if (clear)
			count_next = mmb_pkg::CNT_ZERO;
		else if (inc && count_reg != mmb_pkg::CNT_MAX)
			count_next = count_reg + 16'h0001;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			count_reg <= 16'h0000;
		else
			count_reg <= count_next;
	end

	assign count_q = count_reg;
endmodule : mmb_sat_cnt
`default_nettype wire
